// >>> lcc_pkg.sv
package lcc_pkg;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int TRKL_FILT_MS = 32;
  localparam int TRKL_FILT_CYC = TRKL_FILT_MS * 1000 * CLK_MHZ;
  localparam int EOC_FILT_US = 1000;
  localparam int EOC_FILT_CYC = EOC_FILT_US * CLK_MHZ;
  localparam int SOFT_STEP_US = 100;
  localparam int SOFT_STEP_CYC = SOFT_STEP_US * CLK_MHZ;
  localparam int TCHG_MIN_DEF = 360;
  // A minute of clock cycles does not fit in 32 bits
  localparam longint CYC_PER_MIN = longint'(60) * 1000 * 1000 * CLK_MHZ;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CUR = 8'h01;
  localparam logic [7:0] ADDR_VOLT = 8'h02;
  localparam logic [7:0] ADDR_TMR = 8'h03;
  localparam logic [7:0] ADDR_IRQ = 8'h04;
  localparam logic [7:0] ADDR_STATE = 8'h05;
  localparam logic [7:0] ADDR_WDOG = 8'h06;
  localparam logic [7:0] ADDR_WDKICK = 8'h07;
  // CTRL bits
  localparam int CTRL_DIS = 0;
  localparam int CTRL_FORCE_TRKL = 1;
  localparam int CTRL_THERMISTOR_MONITOR_EN = 2;
  localparam logic [7:0] CTRL_RST = 8'h01;
  // CUR fields: cc[2:0], eoc[5:3]; TRKL select in CUR high bits 7:6
  localparam logic [7:0] CUR_RST = 8'h00;
  localparam logic [1:0] TRKL_SEL_40MA = 2'h0;
  // VOLT fields: float[3:0], ovp[5:4]
  localparam logic [7:0] VOLT_RST = 8'h00;
  localparam logic [7:0] TMR_RST = 8'h06;
  // IRQ bits
  localparam int IRQ_OVP = 1;
  localparam int IRQ_TEMP = 2;
  localparam int IRQ_COMP = 3;
  localparam int IRQ_USBDET = 4;
  localparam int IRQ_BATTERY_DETECT_IRQ = 5;
  localparam int IRQ_TIMEOUT = 6;
  localparam int IRQ_WDOG = 7;

  typedef enum logic [2:0] {
    ST_IDLE, ST_TRKL, ST_CC, ST_CV, ST_DONE, ST_FAULT
  } lcc_state_t;

  typedef struct packed {
    logic in_valid;
    logic bat_above_trkl;
    logic bat_above_rchg;
    logic bat_above_float;
    logic bat_above_ovp;
    logic cur_below_eoc;
    logic temp_ok;
  } lcc_sense_t;

  typedef struct packed {
    logic charger_on;
    logic trickle_on;
    logic [1:0] trkl_sel;
    logic [2:0] cc_sel;
    logic [2:0] cc_ramp;
    logic cv_mode;
    logic [3:0] float_sel;
    logic [1:0] ovp_sel;
    logic [2:0] eoc_sel;
    logic ntc_bias_on;
    logic ntc_charge_window;
  } lcc_drive_t;
endpackage

// >>> lcc_top.sv
// Contract
// (R1) Start only with valid input, enabled, faultless
// (R2) Input-detect interrupt when input valid
// (R3) Fault during charge stops, raises interrupt
// (R4) Normal completion raises complete interrupt
// (R5) Enter precharge below threshold, stay
// (R6) Precharge current selectable, default 40 mA
// (R7) Precharge timeout turns charger off
// (R8) Above threshold moves to constant current
// (R9) Normal precharge limited to quarter timer
// (R10) Timer cleared per phase; bounds quick charge
// (R11) Threshold comparator debounced 32 ms
// (R12) Battery-detect interrupt on rising above threshold
// (R13) Forced precharge: full timer, float ends
// (R14) Precharge to current step ramps gradually
// (R15) Constant current level from bits 2:0
// (R16) Float voltage from four-bit field
// (R17) Over-voltage turns off, raises interrupt
// (R18) End needs recharge level and filtered current
// (R19) Host-programmable charger watchdog timer
// (R20) Charging forces thermistor on, charge window
// (R21) Discharging bias only when monitor enabled
// (R22) Temperature fault interrupts; stops charging
// (R23) Battery-detect fires on both directions
// (R24) Fault holds off until disable toggle/replug
// (R25) Charger state readable as encoded field
`timescale 1ns/100ps
`default_nettype none
module lcc_top
  import lcc_pkg::*;
#(
  parameter int TRKL_FILT = TRKL_FILT_CYC,
  parameter int EOC_FILT = EOC_FILT_CYC,
  parameter int SOFT_STEP = SOFT_STEP_CYC,
  parameter longint MIN_CYC = CYC_PER_MIN
) (
  input wire logic I_SYS_CLK,
  input wire logic I_ARST_N,
  input wire logic [7:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [7:0] O_RDATA,
  input wire lcc_pkg::lcc_sense_t I_SENSE,
  output lcc_pkg::lcc_drive_t O_DRIVE
);
  import lcc_pkg::*;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [7:0] ctrl_reg;
  logic [7:0] cur_reg;
  logic [7:0] volt_reg;
  logic [7:0] tmr_reg;
  logic [7:0] irq_reg;
  logic [7:0] wdog_reg;
  logic [1:0] trkl_sel_reg;
  lcc_state_t state_reg;
  lcc_state_t state_next;
  logic trkl_ok_reg;
  logic [31:0] trkl_cnt_reg;
  logic eoc_ok_reg;
  logic [31:0] eoc_cnt_reg;
  logic [35:0] min_cnt_reg;
  logic [15:0] tchg_reg;
  logic [15:0] wd_cnt_reg;
  logic wd_min_reg;
  logic [31:0] ramp_cnt_reg;
  logic [2:0] ramp_reg;
  logic in_valid_d_reg;
  logic dis_d_reg;
  logic latch_reg;
  logic temp_ok_d_reg;

  wire wr_ctrl = I_WR && I_ADDR == ADDR_CTRL;
  wire dis = ctrl_reg[CTRL_DIS];
  wire force_trkl = ctrl_reg[CTRL_FORCE_TRKL];
  wire charging = state_reg == ST_TRKL || state_reg == ST_CC ||
    state_reg == ST_CV;
  wire charging_next = state_next == ST_TRKL || state_next == ST_CC ||
    state_next == ST_CV;
  wire in_rise = I_SENSE.in_valid && !in_valid_d_reg;
  wire dis_fall = !dis && dis_d_reg;
  wire wd_expired = wdog_reg[7] && wd_cnt_reg >= {8'h00, wdog_reg[6:0], 1'b0}
    && wdog_reg[6:0] != 7'h00;

  function automatic logic [15:0] tchg_limit(input logic [7:0] t,
                                            input logic quarter);
    logic [15:0] full;
    full = {8'h00, t} * 16'd30;
    tchg_limit = quarter ? {2'b00, full[15:2]} : full;
  endfunction

  wire [15:0] lim_trkl = tchg_limit(tmr_reg, !force_trkl); // (R9)
  wire [15:0] lim_qc = tchg_limit(tmr_reg, 1'b0);

  // ---------------------------------------------------------------
  // Host register writes
  // ---------------------------------------------------------------
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      ctrl_reg <= CTRL_RST;
      cur_reg <= CUR_RST;
      volt_reg <= VOLT_RST;
      tmr_reg <= TMR_RST;
      wdog_reg <= 8'h00;
      trkl_sel_reg <= TRKL_SEL_40MA; // (R6)
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= I_WDATA;
      end
      if (I_WR && I_ADDR == ADDR_CUR) begin
        cur_reg <= I_WDATA;
        trkl_sel_reg <= I_WDATA[7:6]; // (R6)
      end
      if (I_WR && I_ADDR == ADDR_VOLT) begin
        volt_reg <= I_WDATA;
      end
      if (I_WR && I_ADDR == ADDR_TMR) begin
        tmr_reg <= I_WDATA;
      end
      if (I_WR && I_ADDR == ADDR_WDOG) begin
        wdog_reg <= I_WDATA; // (R19)
      end
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_RDATA <= 8'h00;
    end else if (I_RD) begin
      unique case (I_ADDR)
        ADDR_CTRL: O_RDATA <= ctrl_reg;
        ADDR_CUR: O_RDATA <= {trkl_sel_reg, cur_reg[5:0]};
        ADDR_VOLT: O_RDATA <= volt_reg;
        ADDR_TMR: O_RDATA <= tmr_reg;
        ADDR_IRQ: O_RDATA <= irq_reg;
        ADDR_STATE: O_RDATA <= {5'h00, state_reg}; // (R25)
        ADDR_WDOG: O_RDATA <= wdog_reg;
        default: O_RDATA <= 8'h00;
      endcase
    end else begin
      O_RDATA <= 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // Comparator filters
  // ---------------------------------------------------------------
  // Long debounce keeps chatter near 3.0 V from bouncing phases
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      trkl_ok_reg <= 1'b0;
      trkl_cnt_reg <= 32'h0;
    end else if (I_SENSE.bat_above_trkl == trkl_ok_reg) begin
      trkl_cnt_reg <= 32'h0;
    end else if (trkl_cnt_reg >= 32'(TRKL_FILT - 1)) begin
      trkl_ok_reg <= I_SENSE.bat_above_trkl; // (R11)
      trkl_cnt_reg <= 32'h0;
    end else begin
      trkl_cnt_reg <= trkl_cnt_reg + 32'h1;
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      eoc_ok_reg <= 1'b0;
      eoc_cnt_reg <= 32'h0;
    end else if (!I_SENSE.cur_below_eoc || state_reg != ST_CV) begin
      eoc_ok_reg <= 1'b0;
      eoc_cnt_reg <= 32'h0;
    end else if (eoc_cnt_reg >= 32'(EOC_FILT - 1)) begin
      eoc_ok_reg <= 1'b1; // (R18)
    end else begin
      eoc_cnt_reg <= eoc_cnt_reg + 32'h1;
    end
  end

  // ---------------------------------------------------------------
  // Charge and watchdog timers, counted in minutes
  // ---------------------------------------------------------------
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      min_cnt_reg <= 36'h0;
      wd_min_reg <= 1'b0;
      tchg_reg <= 16'h0;
    end else begin
      wd_min_reg <= min_cnt_reg >= 36'(MIN_CYC - 1);
      if (state_next != state_reg || !charging) begin
        min_cnt_reg <= 36'h0;
        tchg_reg <= 16'h0; // (R10)
      end else if (min_cnt_reg >= 36'(MIN_CYC - 1)) begin
        min_cnt_reg <= 36'h0;
        tchg_reg <= tchg_reg + 16'h1;
      end else begin
        min_cnt_reg <= min_cnt_reg + 36'h1;
      end
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      wd_cnt_reg <= 16'h0;
    end else if ((I_WR && I_ADDR == ADDR_WDKICK) || !wdog_reg[7] ||
                 !charging) begin
      wd_cnt_reg <= 16'h0; // (R19)
    end else if (wd_min_reg && !wd_expired) begin
      wd_cnt_reg <= wd_cnt_reg + 16'h1;
    end
  end

  // ---------------------------------------------------------------
  // Charger state machine
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (I_SENSE.in_valid && !dis && !latch_reg &&
            I_SENSE.temp_ok && !I_SENSE.bat_above_ovp) begin // (R1)
          state_next = (!trkl_ok_reg || force_trkl) ? ST_TRKL : ST_CC; // (R5)
        end
      end
      ST_TRKL: begin
        if (tchg_reg >= lim_trkl) begin
          state_next = ST_FAULT; // (R7)
        end else if (force_trkl && I_SENSE.bat_above_float) begin
          state_next = ST_DONE; // (R13)
        end else if (!force_trkl && trkl_ok_reg) begin
          state_next = ST_CC; // (R8)
        end
      end
      ST_CC: begin
        if (tchg_reg >= lim_qc) begin
          state_next = ST_FAULT; // (R10)
        end else if (I_SENSE.bat_above_float) begin
          state_next = ST_CV; // (R16)
        end
      end
      ST_CV: begin
        if (tchg_reg >= lim_qc) begin
          state_next = ST_FAULT; // (R10)
        end else if (eoc_ok_reg && I_SENSE.bat_above_rchg) begin
          state_next = ST_DONE; // (R18)
        end
      end
      ST_DONE: begin
        if (!I_SENSE.in_valid || dis) begin
          state_next = ST_IDLE;
        end
      end
      ST_FAULT: begin
        if (!latch_reg) begin
          state_next = ST_IDLE; // (R24)
        end
      end
    endcase
    // Faults override every charging phase
    if (charging && (!I_SENSE.in_valid || dis)) begin
      state_next = ST_IDLE;
    end
    if (charging && (I_SENSE.bat_above_ovp || !I_SENSE.temp_ok ||
        wd_expired)) begin
      state_next = ST_FAULT; // (R3) (R17) (R22)
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Fault latch; cleared by disable toggle or input replug
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      latch_reg <= 1'b0;
      in_valid_d_reg <= 1'b0;
      dis_d_reg <= 1'b0;
      temp_ok_d_reg <= 1'b1;
    end else begin
      in_valid_d_reg <= I_SENSE.in_valid;
      dis_d_reg <= dis;
      temp_ok_d_reg <= I_SENSE.temp_ok;
      // Set only on entry, else the latch would hold itself forever
      if (state_next == ST_FAULT && state_reg != ST_FAULT) begin
        latch_reg <= 1'b1;
      end else if (dis_fall || in_rise) begin
        latch_reg <= 1'b0; // (R24)
      end
    end
  end

  // ---------------------------------------------------------------
  // Interrupt flags; a new event beats a same-cycle clear
  // ---------------------------------------------------------------
  logic [7:0] irq_set;
  logic trkl_ok_d_reg;
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      trkl_ok_d_reg <= 1'b0;
    end else begin
      trkl_ok_d_reg <= trkl_ok_reg;
    end
  end

  always_comb begin
    irq_set = 8'h00;
    irq_set[IRQ_USBDET] = in_rise; // (R2)
    irq_set[IRQ_BATTERY_DETECT_IRQ] = trkl_ok_reg != trkl_ok_d_reg; // (R12) (R23)
    irq_set[IRQ_OVP] = charging && I_SENSE.bat_above_ovp; // (R17)
    // Temperature checked while charging, and in discharge only when monitor enabled
    irq_set[IRQ_TEMP] = !I_SENSE.temp_ok && temp_ok_d_reg &&
      (charging || ctrl_reg[CTRL_THERMISTOR_MONITOR_EN]); // (R22)
    irq_set[IRQ_COMP] = state_next == ST_DONE && state_reg != ST_DONE; // (R4)
    irq_set[IRQ_TIMEOUT] = state_next == ST_FAULT && // (R3) (R7)
      ((state_reg == ST_TRKL && tchg_reg >= lim_trkl) ||
      ((state_reg == ST_CC || state_reg == ST_CV) && tchg_reg >= lim_qc));
    irq_set[IRQ_WDOG] = charging && wd_expired; // (R3)
  end

  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      irq_reg <= 8'h00;
    end else if (I_WR && I_ADDR == ADDR_IRQ) begin
      irq_reg <= (irq_reg & ~I_WDATA) | irq_set;
    end else begin
      irq_reg <= irq_reg | irq_set;
    end
  end

  // ---------------------------------------------------------------
  // Soft ramp of current level after precharge
  // ---------------------------------------------------------------
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      ramp_reg <= 3'h0;
      ramp_cnt_reg <= 32'h0;
    end else if (state_reg != ST_CC && state_reg != ST_CV) begin
      ramp_reg <= 3'h0;
      ramp_cnt_reg <= 32'h0;
    end else if (ramp_reg > cur_reg[2:0]) begin
      ramp_reg <= cur_reg[2:0];
    end else if (ramp_reg != cur_reg[2:0]) begin
      if (ramp_cnt_reg >= 32'(SOFT_STEP - 1)) begin
        ramp_cnt_reg <= 32'h0;
        ramp_reg <= ramp_reg + 3'h1; // (R14)
      end else begin
        ramp_cnt_reg <= ramp_cnt_reg + 32'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Analog controls
  // ---------------------------------------------------------------
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_DRIVE <= '0;
    end else begin
      O_DRIVE.charger_on <= state_next == ST_CC || state_next == ST_CV;
      O_DRIVE.trickle_on <= state_next == ST_TRKL;
      O_DRIVE.trkl_sel <= trkl_sel_reg; // (R6)
      O_DRIVE.cc_sel <= cur_reg[2:0]; // (R15)
      // Clamp so a lowered setting never sees the ramp above it
      O_DRIVE.cc_ramp <= (ramp_reg > cur_reg[2:0]) ? cur_reg[2:0] :
        ramp_reg; // (R14)
      O_DRIVE.cv_mode <= state_next == ST_CV; // (R16)
      O_DRIVE.float_sel <= volt_reg[3:0]; // (R16)
      O_DRIVE.ovp_sel <= volt_reg[5:4]; // (R17)
      O_DRIVE.eoc_sel <= cur_reg[5:3]; // (R18)
      O_DRIVE.ntc_bias_on <= charging_next ||
        ctrl_reg[CTRL_THERMISTOR_MONITOR_EN]; // (R20) (R21)
      O_DRIVE.ntc_charge_window <= charging_next; // (R20) (R21)
    end
  end
endmodule
`default_nettype wire

// >>> lcc_top_chk.sv
`timescale 1ns/100ps
`default_nettype none
module lcc_top_chk
  import lcc_pkg::*;
(
  input wire logic I_SYS_CLK,
  input wire logic I_ARST_N,
  input wire logic [7:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic [7:0] O_RDATA,
  input wire lcc_pkg::lcc_sense_t I_SENSE,
  input wire lcc_pkg::lcc_drive_t O_DRIVE
);
  // ------
  // Checks
  // ------
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_ARST_N);
  logic chg;
  assign chg = O_DRIVE.charger_on | O_DRIVE.trickle_on;

  chk_rdata_idle: assert property (
    !$past(I_RD) |-> O_RDATA == 8'h00) else $error("read data not idle");
  chk_no_input: assert property (
    !I_SENSE.in_valid |=> !chg) else $error("charging without input");
  chk_dis_stops: assert property (
    I_WR && I_ADDR == ADDR_CTRL && I_WDATA[CTRL_DIS] |=> ##1 !chg)
    else $error("disable did not stop charge");
  chk_ovp_off: assert property (
    I_SENSE.bat_above_ovp |=> !chg) else $error("overvoltage kept on");
  chk_temp_off: assert property (
    chg && !I_SENSE.temp_ok |=> !chg) else $error("hot charge kept on");
  chk_bias_charge: assert property (
    chg |-> O_DRIVE.ntc_bias_on && O_DRIVE.ntc_charge_window)
    else $error("thermistor not forced while charging");
  chk_ramp_step: assert property (
    O_DRIVE.cc_ramp > $past(O_DRIVE.cc_ramp)
    |-> O_DRIVE.cc_ramp == $past(O_DRIVE.cc_ramp) + 3'h1)
    else $error("ramp jumped");
  chk_ramp_limit: assert property (
    O_DRIVE.cc_ramp <= O_DRIVE.cc_sel) else $error("ramp above setting");

  cover property ($rose(O_DRIVE.cv_mode));
  cover property ($fell(O_DRIVE.trickle_on) && O_DRIVE.charger_on);
  cover property (chg && !I_SENSE.temp_ok);
endmodule
bind lcc_top lcc_top_chk i_chk (
  .I_SYS_CLK(I_SYS_CLK),
  .I_ARST_N(I_ARST_N),
  .I_ADDR(I_ADDR),
  .I_WDATA(I_WDATA),
  .I_WR(I_WR),
  .I_RD(I_RD),
  .O_RDATA(O_RDATA),
  .I_SENSE(I_SENSE),
  .O_DRIVE(O_DRIVE)
);
`default_nettype wire

// >>> lcc_batt.sv
`timescale 1ns/100ps
`default_nettype none
module lcc_batt
  import lcc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire lcc_pkg::lcc_drive_t i_drive,
  input wire logic i_plug,
  input wire logic [1:0] i_rate,
  input wire logic i_hot,
  input wire logic i_ovp,
  input wire logic i_drain,
  output lcc_pkg::lcc_sense_t o_sense
);
  // -------------
  // Cell charge
  // -------------
  // Rate 0 models a dead cell that never lifts
  logic [7:0] lvl_reg;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lvl_reg <= 8'h00;
    end else if (i_drain) begin
      lvl_reg <= 8'h00;
    end else if ((i_drive.charger_on | i_drive.trickle_on) &&
                 lvl_reg < 8'hF0) begin
      lvl_reg <= lvl_reg + {6'h00, i_rate};
    end
  end
  always_comb begin
    o_sense.in_valid = i_plug;
    o_sense.bat_above_trkl = lvl_reg > 8'h28;
    o_sense.bat_above_rchg = lvl_reg > 8'h80;
    o_sense.bat_above_float = lvl_reg > 8'hA0;
    o_sense.bat_above_ovp = i_ovp;
    o_sense.cur_below_eoc = i_drive.cv_mode && lvl_reg > 8'hB0;
    o_sense.temp_ok = !i_hot;
  end
endmodule
`default_nettype wire

// >>> lcc_top_bench.sv
`timescale 1ns/100ps
`default_nettype none
module lcc_top_bench;
  import lcc_pkg::*;
  logic sys_clk, arst_n, wr_stb, rd_stb, plug, hot, ovp, drain;
  logic [7:0] addr, wdata, rdata;
  logic [1:0] rate;
  lcc_sense_t sense;
  lcc_drive_t drive;
  int fail_count = 0;
  int compares = 0;
  int cyc = 0;

  // Short counts: precharge limit is 180 cycles
  lcc_top #(.TRKL_FILT(8), .EOC_FILT(4), .SOFT_STEP(2), .MIN_CYC(4)) i_dut (
    .I_SYS_CLK(sys_clk), .I_ARST_N(arst_n), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr_stb), .I_RD(rd_stb), .O_RDATA(rdata),
    .I_SENSE(sense), .O_DRIVE(drive));
  lcc_batt i_batt (
    .i_clk(sys_clk), .i_arst_n(arst_n), .i_drive(drive), .i_plug(plug),
    .i_rate(rate), .i_hot(hot), .i_ovp(ovp), .i_drain(drain),
    .o_sense(sense));

  always #2.5 sys_clk = ~sys_clk;

  // ----------
  // Bus tasks
  // ----------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge sys_clk);
    wr_stb <= 1'b0;
  endtask
  task automatic peek(input logic [7:0] a, output logic [7:0] q);
    @(posedge sys_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge sys_clk);
    rd_stb <= 1'b0;
    @(negedge sys_clk);
    q = rdata;
    @(posedge sys_clk);
  endtask
  task automatic check(input string n, input logic [7:0] e,
                       input logic [7:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rdm(input logic [7:0] a, input logic [7:0] m,
                     input logic [7:0] e);
    logic [7:0] q;
    peek(a, q);
    check($sformatf("reg %h", a), e, q & m);
  endtask
  task automatic wait_st(input logic [7:0] e);
    logic [7:0] q;
    q = 8'hFF;
    for (int i = 0; i < 200 && q !== e; i++) begin
      peek(ADDR_STATE, q);
    end
    check("state", e, q);
  endtask
  task automatic restart();
    wr(ADDR_IRQ, 8'hFF);
    wr(ADDR_CTRL, 8'h01);
    wr(ADDR_CTRL, 8'h00);
  endtask
  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Whole run needs under 2000 cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 6000) begin
      fail_count++;
      stop_test();
    end
  end

  // ---------
  // Sequence
  // ---------
  initial begin
    sys_clk = 1'b0;
    arst_n = 1'b0;
    {wr_stb, rd_stb, plug, hot, ovp, drain} = 6'h00;
    {addr, wdata} = 16'h0000;
    rate = 2'h0;
    repeat (16) @(posedge sys_clk);
    arst_n <= 1'b1;
    rdm(ADDR_CTRL, 8'hFF, CTRL_RST);
    rdm(ADDR_TMR, 8'hFF, TMR_RST);
    rdm(ADDR_STATE, 8'hFF, 8'h00);
    rdm(8'h08, 8'hFF, 8'h00);
    plug <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rdm(ADDR_IRQ, 8'hFF, 8'h10);
    rdm(ADDR_STATE, 8'hFF, 8'h00);
    wr(ADDR_IRQ, 8'hFF);
    wr(ADDR_CUR, 8'h2D);
    wr(ADDR_VOLT, 8'h23);
    wr(ADDR_CTRL, 8'h00);
    wait_st(8'h01);
    check("trickle", 8'h01, {7'h00, drive.trickle_on});
    check("trkl_sel", 8'h00, {6'h00, drive.trkl_sel});
    repeat (140) @(posedge sys_clk);
    rdm(ADDR_STATE, 8'hFF, 8'h01);
    repeat (50) @(posedge sys_clk);
    rdm(ADDR_STATE, 8'hFF, 8'h05);
    rdm(ADDR_IRQ, 8'hFF, 8'h40);
    repeat (10) @(posedge sys_clk);
    rdm(ADDR_STATE, 8'hFF, 8'h05);
    rate <= 2'h1;
    restart();
    wait_st(8'h02);
    rdm(ADDR_IRQ, 8'h20, 8'h20);
    check("cc_sel", 8'h05, {5'h00, drive.cc_sel});
    check("charger_on", 8'h01, {7'h00, drive.charger_on});
    repeat (20) @(posedge sys_clk);
    check("cc_ramp", 8'h05, {5'h00, drive.cc_ramp});
    wait_st(8'h03);
    check("float_sel", 8'h03, {4'h0, drive.float_sel});
    check("cv_mode", 8'h01, {7'h00, drive.cv_mode});
    check("ovp_sel", 8'h02, {6'h00, drive.ovp_sel});
    check("eoc_sel", 8'h05, {5'h00, drive.eoc_sel});
    wait_st(8'h04);
    rdm(ADDR_IRQ, 8'h08, 8'h08);
    wr(ADDR_IRQ, 8'hFF);
    drain <= 1'b1;
    repeat (20) @(posedge sys_clk);
    rdm(ADDR_IRQ, 8'h20, 8'h20);
    drain <= 1'b0;
    restart();
    wait_st(8'h01);
    ovp <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rdm(ADDR_STATE, 8'hFF, 8'h05);
    rdm(ADDR_IRQ, 8'h02, 8'h02);
    ovp <= 1'b0;
    restart();
    wait_st(8'h01);
    hot <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rdm(ADDR_STATE, 8'hFF, 8'h05);
    rdm(ADDR_IRQ, 8'h04, 8'h04);
    wr(ADDR_CTRL, 8'h01);
    repeat (3) @(posedge sys_clk);
    check("bias_off", 8'h00, {7'h00, drive.ntc_bias_on});
    wr(ADDR_CTRL, 8'h05);
    repeat (3) @(posedge sys_clk);
    check("bias_on", 8'h01, {7'h00, drive.ntc_bias_on});
    check("window", 8'h00, {7'h00, drive.ntc_charge_window});
    // Forced precharge outlasts the quarter limit on a stalled cell
    hot <= 1'b0;
    rate <= 2'h0;
    wr(ADDR_IRQ, 8'hFF);
    wr(ADDR_CTRL, 8'h02);
    wait_st(8'h01);
    repeat (200) @(posedge sys_clk);
    rdm(ADDR_STATE, 8'hFF, 8'h01);
    rate <= 2'h1;
    wait_st(8'h04);
    rdm(ADDR_IRQ, 8'h08, 8'h08);
    wr(ADDR_WDOG, 8'h81);
    rdm(ADDR_WDOG, 8'hFF, 8'h81);
    rate <= 2'h0;
    restart();
    wait_st(8'h05);
    rdm(ADDR_IRQ, 8'hC0, 8'h80);
    wr(ADDR_WDOG, 8'h00);
    plug <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rdm(ADDR_STATE, 8'hFF, 8'h05);
    plug <= 1'b1;
    wait_st(8'h03);
    rdm(ADDR_IRQ, 8'h10, 8'h10);
    stop_test();
  end
endmodule
`default_nettype wire
